// ===== logic/apcg_top.sv
// How it works
// R01 - Reference clock stays within 512kHz to 20MHz
// R02 - Register 5 bit 7 powers PLL
// R03 - Output is ref times mult times whole.frac over ref_scale
// R04 - Software keeps all PLL fields in range
// R05 - ref_scale from register 5 bits 6:4, reset one
// R06 - mult_scale from register 5 bits 3:0, reset one
// R07 - whole_mult from register 6 bits 5:0, reset four
// R08 - frac_part from registers 7 and 8, reset zero
// R09 - New frac_part applied only on lower write
// R10 - Integer mode: ref over ref_scale 512kHz-20MHz
// R11 - Fractional mode: ref over ref_scale 10-20MHz
// R12 - Software keeps PLL output in range window
// R13 - PLL output usable about 10ms after power-up
// R14 - PLL runs alone, routable to GPIO output
// R15 - Register 4 bits 1:0 pick root clock
// R16 - PLL up first, down last when root
// R17 - Parent dividers powered down after children
// R18 - PLL path gated until settle counter expires
// R19 - Source select encoding is parameterised lookup
`timescale 1ns/100ps

module apcg_top
    import apcg_pkg::*;
#(
    parameter int         SETTLE_CYCLES = APCG_SETTLE_CYCLES,
    parameter logic [1:0] CODE_MCLK     = APCG_SEL_MCLK,
    parameter logic [1:0] CODE_BCLK     = APCG_SEL_BCLK,
    parameter logic [1:0] CODE_GPIO     = APCG_SEL_GPIO,
    parameter logic [1:0] CODE_PLL      = APCG_SEL_PLL
)
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_page,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_r,
    input  wire logic        mclk_pin,
    input  wire logic        bclk_pin,
    input  wire logic        gpio_pin,
    input  wire logic        pll_clock_in,
    input  wire logic        pll_gpio_route,
    output logic             pll_enable_r,
    output logic             pll_range_mode_r,
    output logic      [2:0]  pll_ref_scale_r,
    output logic      [3:0]  pll_mult_scale_r,
    output logic      [5:0]  pll_whole_mult_r,
    output logic      [13:0] pll_frac_part_r,
    output logic      [1:0]  root_src_sel_r,
    output logic             pll_usable_r,
    output logic             codec_root_clock_r,
    output logic             gpio_clock_out_r
);

    import apcg_pkg::*;

    // ==========================================================
    // Declarations
    logic [7:0]               root_reg_r;
    logic [7:0]               ctrl_reg_r;
    logic [7:0]               whole_reg_r;
    logic [7:0]               frac_up_reg_r;
    logic [7:0]               frac_lo_reg_r;
    logic [APCG_SETTLE_W-1:0] settle_cnt_r;
    logic                     pll_en_d_r;
    logic [3:0]               src_sync;
    logic [3:0]               src_gated;
    logic                     page_hit;
    logic                     wr_hit;
    apcg_src_type             src_idx;

    // Decode a select code into a source index through the lookup
    function automatic apcg_src_type code_to_src(input logic [1:0] code);
        apcg_src_type s;
        s = APCG_SRC_MCLK;
        if (code == CODE_BCLK)
            s = APCG_SRC_BCLK;
        else if (code == CODE_GPIO)
            s = APCG_SRC_GPIO;
        else if (code == CODE_PLL)
            s = APCG_SRC_PLL;
        return s;                                           // [R19]
    endfunction

    // Register match helper, used for each write and read decode
    function automatic logic addr_is(input logic [6:0] a,
                                     input logic [6:0] ofs);
        return a == ofs;
    endfunction

    assign page_hit = (reg_page == APCG_PAGE_ZERO);
    assign wr_hit   = reg_wr && page_hit;

    // ==========================================================
    // Register file writes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            root_reg_r    <= APCG_RST_ROOT_SEL;
            ctrl_reg_r    <= APCG_RST_PLL_CTRL;               // [R05] [R06]
            whole_reg_r   <= APCG_RST_PLL_WHOLE;              // [R07]
            frac_up_reg_r <= APCG_RST_FRAC_UPPER;
            frac_lo_reg_r <= APCG_RST_FRAC_LOWER;
        end
        else if (ce && wr_hit)
        begin
            if (addr_is(reg_addr, APCG_OFS_ROOT_SEL))
                root_reg_r <= reg_wdata;
            if (addr_is(reg_addr, APCG_OFS_PLL_CTRL))
                ctrl_reg_r <= reg_wdata;
            if (addr_is(reg_addr, APCG_OFS_PLL_WHOLE))
                whole_reg_r <= reg_wdata;
            if (addr_is(reg_addr, APCG_OFS_FRAC_UPPER))
                frac_up_reg_r <= reg_wdata;
            if (addr_is(reg_addr, APCG_OFS_FRAC_LOWER))
                frac_lo_reg_r <= reg_wdata;
        end
    end

    // ==========================================================
    // Register reads, unmapped addresses and other pages read zero
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rdata_r <= 8'h00;
        else if (ce && reg_rd)
        begin
            if (!page_hit)
                reg_rdata_r <= 8'h00;
            else if (addr_is(reg_addr, APCG_OFS_ROOT_SEL))
                reg_rdata_r <= root_reg_r;
            else if (addr_is(reg_addr, APCG_OFS_PLL_CTRL))
                reg_rdata_r <= ctrl_reg_r;
            else if (addr_is(reg_addr, APCG_OFS_PLL_WHOLE))
                reg_rdata_r <= whole_reg_r;
            else if (addr_is(reg_addr, APCG_OFS_FRAC_UPPER))
                reg_rdata_r <= frac_up_reg_r;
            else if (addr_is(reg_addr, APCG_OFS_FRAC_LOWER))
                reg_rdata_r <= frac_lo_reg_r;
            else
                reg_rdata_r <= 8'h00;
        end
    end

    // ==========================================================
    // PLL settings toward the analog core
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_enable_r     <= 1'b0;
            pll_range_mode_r <= 1'b0;
            pll_ref_scale_r  <= APCG_RST_PLL_CTRL[6:4];
            pll_mult_scale_r <= APCG_RST_PLL_CTRL[3:0];
            pll_whole_mult_r <= APCG_RST_PLL_WHOLE[5:0];
            root_src_sel_r   <= APCG_RST_ROOT_SEL[1:0];
        end
        else if (ce)
        begin
            pll_enable_r     <= ctrl_reg_r[APCG_PLL_EN_BIT];     // [R02]
            pll_range_mode_r <= root_reg_r[APCG_RANGE_BIT];
            pll_ref_scale_r  <=
                ctrl_reg_r[APCG_REF_SCALE_MSB:APCG_REF_SCALE_LSB]; // [R05] [R03]
            pll_mult_scale_r <=
                ctrl_reg_r[APCG_MULT_SCALE_MSB:APCG_MULT_SCALE_LSB]; // [R06] [R03]
            pll_whole_mult_r <=
                whole_reg_r[APCG_WHOLE_MSB:APCG_WHOLE_LSB];     // [R07] [R03]
            root_src_sel_r   <=
                root_reg_r[APCG_ROOT_SEL_MSB:APCG_ROOT_SEL_LSB]; // [R15]
        end
    end

    // ==========================================================
    // Fraction applied only when the lower byte is written
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pll_frac_part_r <= 14'h0000;                        // [R08]
        else if (ce && wr_hit && addr_is(reg_addr, APCG_OFS_FRAC_LOWER))
            pll_frac_part_r <= {frac_up_reg_r[APCG_FRAC_UP_MSB:0],
                                reg_wdata};                     // [R09] [R08]
    end

    // ==========================================================
    // Settle counter, restarted on each PLL power-up
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_en_d_r   <= 1'b0;
            settle_cnt_r <= '0;
            pll_usable_r <= 1'b0;
        end
        else if (ce)
        begin
            pll_en_d_r <= pll_enable_r;
            if (!pll_enable_r)
            begin
                settle_cnt_r <= '0;
                pll_usable_r <= 1'b0;
            end
            else if (!pll_en_d_r)
            begin
                settle_cnt_r <= APCG_SETTLE_W'(SETTLE_CYCLES);  // [R13]
                pll_usable_r <= 1'b0;
            end
            else if (settle_cnt_r != '0)
                settle_cnt_r <= settle_cnt_r - 1'b1;
            else
                pll_usable_r <= 1'b1;                           // [R13] [R18]
        end
    end

    // ==========================================================
    // Pin and PLL clocks brought into the clock domain
    apcg_sync #(.WIDTH(4)) u_sync
    (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .async_in ({pll_clock_in, gpio_pin, bclk_pin, mclk_pin}),
        .sync_out (src_sync)
    );

    // PLL path held low until settled
    assign src_gated = {src_sync[3] & pll_usable_r, src_sync[2:0]}; // [R18]
    assign src_idx   = code_to_src(root_src_sel_r);

    // ==========================================================
    // Root clock mux and general purpose PLL output
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            codec_root_clock_r <= 1'b0;
            gpio_clock_out_r   <= 1'b0;
        end
        else if (ce)
        begin
            unique case (src_idx)
                APCG_SRC_MCLK: codec_root_clock_r <= src_gated[0];
                APCG_SRC_BCLK: codec_root_clock_r <= src_gated[1];
                APCG_SRC_GPIO: codec_root_clock_r <= src_gated[2];
                APCG_SRC_PLL:  codec_root_clock_r <= src_gated[3]; // [R15]
            endcase
            gpio_clock_out_r <= pll_gpio_route & src_gated[3];  // [R14]
        end
    end

endmodule

// ===== logic/apcg_pkg.sv
package apcg_pkg;

    // ==========================================================
    // Register offsets (page 0)
    localparam logic [6:0] APCG_OFS_ROOT_SEL   = 7'h04;
    localparam logic [6:0] APCG_OFS_PLL_CTRL   = 7'h05;
    localparam logic [6:0] APCG_OFS_PLL_WHOLE  = 7'h06;
    localparam logic [6:0] APCG_OFS_FRAC_UPPER = 7'h07;
    localparam logic [6:0] APCG_OFS_FRAC_LOWER = 7'h08;
    localparam logic [7:0] APCG_PAGE_ZERO      = 8'h00;

    // ==========================================================
    // Field positions
    localparam int APCG_ROOT_SEL_LSB   = 0;
    localparam int APCG_ROOT_SEL_MSB   = 1;
    localparam int APCG_RANGE_BIT      = 6;
    localparam int APCG_PLL_EN_BIT     = 7;
    localparam int APCG_REF_SCALE_LSB  = 4;
    localparam int APCG_REF_SCALE_MSB  = 6;
    localparam int APCG_MULT_SCALE_LSB = 0;
    localparam int APCG_MULT_SCALE_MSB = 3;
    localparam int APCG_WHOLE_LSB      = 0;
    localparam int APCG_WHOLE_MSB      = 5;
    localparam int APCG_FRAC_UP_MSB    = 5;

    // ==========================================================
    // Reset values
    localparam logic [7:0] APCG_RST_ROOT_SEL   = 8'h00;
    localparam logic [7:0] APCG_RST_PLL_CTRL   = 8'h11;
    localparam logic [7:0] APCG_RST_PLL_WHOLE  = 8'h04;
    localparam logic [7:0] APCG_RST_FRAC_UPPER = 8'h00;
    localparam logic [7:0] APCG_RST_FRAC_LOWER = 8'h00;

    // ==========================================================
    // Root clock source select codes
    localparam logic [1:0] APCG_SEL_MCLK = 2'h0;
    localparam logic [1:0] APCG_SEL_BCLK = 2'h1;
    localparam logic [1:0] APCG_SEL_GPIO = 2'h2;
    localparam logic [1:0] APCG_SEL_PLL  = 2'h3;

    // Source index into the synchronised clock vector
    typedef enum logic [1:0]
    {
        APCG_SRC_MCLK = 2'b00,
        APCG_SRC_BCLK = 2'b01,
        APCG_SRC_GPIO = 2'b10,
        APCG_SRC_PLL  = 2'b11
    } apcg_src_type;

    // ==========================================================
    // Timing
    localparam int APCG_CLK_KHZ      = 250000;
    localparam int APCG_SETTLE_MS    = 10;
    localparam int APCG_SETTLE_CYCLES = APCG_SETTLE_MS * APCG_CLK_KHZ;
    localparam int APCG_SETTLE_W     = 22;

endpackage

// ===== logic/apcg_sync.sv
`timescale 1ns/100ps

// Two flip-flop synchroniser for a group of independent levels
module apcg_sync
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // ==========================================================
    // Synchroniser stages, one per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clock or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta_r[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else if (ce)
                begin
                    meta_r[i]   <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule

// ===== testbench/apcg_clk_src.sv
`timescale 1ns/100ps

// ==========================================================
// Clock sources on the pins, free running, off the 4 ns grid
module apcg_clk_src
(
    output logic mclk_pin,
    output logic bclk_pin,
    output logic gpio_pin,
    output logic pll_clock_in
);
    // Start every source low
    initial
    begin
        {mclk_pin, bclk_pin, gpio_pin, pll_clock_in} = 4'h0;
    end
    // Half periods are multiples of 0.8 ns, so no source edge ever
    // lands on a rising clock edge and races the synchroniser
    // Reference near 12.25 MHz, inside the PLL input band
    always #40.8 pll_clock_in = ~pll_clock_in;
    // Slow pin clocks so sampling keeps every edge
    always #30.4 mclk_pin = ~mclk_pin;
    always #50.4 bclk_pin = ~bclk_pin;
    always #70.4 gpio_pin = ~gpio_pin;
endmodule

// ===== testbench/apcg_checker.sv
`timescale 1ns/100ps

// ==========================================================
// Port checks for the clock generator
module apcg_checker
    import apcg_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20
)
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic [7:0]  reg_page,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_r,
    input wire logic        bclk_pin,
    input wire logic        pll_enable_r,
    input wire logic        pll_range_mode_r,
    input wire logic [2:0]  pll_ref_scale_r,
    input wire logic [3:0]  pll_mult_scale_r,
    input wire logic [5:0]  pll_whole_mult_r,
    input wire logic [13:0] pll_frac_part_r,
    input wire logic [1:0]  root_src_sel_r,
    input wire logic        pll_usable_r,
    input wire logic        codec_root_clock_r
);
    // Rise of usable lands 22 samples after the enable rises
    localparam int S_LO = SETTLE_CYCLES - 6;
    localparam int S_HI = SETTLE_CYCLES - 6;
    logic wt;
    // Write taken on page zero
    assign wt = ce && reg_wr && reg_page == 8'h00;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_ctrl_fields: assert property (
        wt && reg_addr == 7'h05 |-> ##2 {pll_enable_r, pll_ref_scale_r,
        pll_mult_scale_r} == $past(reg_wdata, 2)) else $error("ctrl bad");
    a_whole_field: assert property (
        wt && reg_addr == 7'h06 |-> ##2 {2'b00, pll_whole_mult_r}
        == ($past(reg_wdata, 2) & 8'h3F)) else $error("whole bad");
    a_root_fields: assert property (
        wt && reg_addr == 7'h04 |-> ##2 {1'b0, pll_range_mode_r, 4'h0,
        root_src_sel_r} == ($past(reg_wdata, 2) & 8'h43)) else $error("sel");
    a_frac_apply: assert property (
        wt && reg_addr == 7'h08 |=> pll_frac_part_r[7:0]
        == $past(reg_wdata)) else $error("frac not applied");
    a_frac_hold: assert property (
        !(wt && reg_addr == 7'h08) |=> $stable(pll_frac_part_r))
        else $error("frac changed early");
    a_page_refuse: assert property (
        ce && reg_rd && reg_page != 8'h00 |=> reg_rdata_r == 8'h00)
        else $error("other page read");
    a_usable_off: assert property (
        !pll_enable_r |=> !pll_usable_r) else $error("usable while off");
    a_settle_time: assert property (
        $rose(pll_enable_r) |-> (!pll_usable_r) [*8] ##[S_LO:S_HI]
        (!pll_usable_r ##1 pll_usable_r)) else $error("settle time wrong");
    a_bclk_path: assert property (
        (root_src_sel_r == APCG_SEL_BCLK) [*4] |->
        codec_root_clock_r == $past(bclk_pin, 3)) else $error("bclk path");
    a_pll_gated: assert property (
        (root_src_sel_r == APCG_SEL_PLL && !pll_usable_r) [*4] |->
        !codec_root_clock_r) else $error("pll clock leaked");
endmodule

bind apcg_top apcg_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk
(
    .clock, .resetn, .ce, .reg_page, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_r, .bclk_pin, .pll_enable_r, .pll_range_mode_r,
    .pll_ref_scale_r, .pll_mult_scale_r, .pll_whole_mult_r,
    .pll_frac_part_r, .root_src_sel_r, .pll_usable_r, .codec_root_clock_r
);

// ===== testbench/apcg_top_tb.sv
`timescale 1ns/100ps

module apcg_top_tb;
    import apcg_pkg::*;
    localparam int SETTLE = 20;
    logic        clock, resetn, ce, reg_wr, reg_rd, pll_gpio_route;
    logic [7:0]  reg_page, reg_wdata, reg_rdata_r, v;
    logic [6:0]  reg_addr;
    logic        mclk_pin, bclk_pin, gpio_pin, pll_clock_in;
    logic        pll_enable_r, pll_range_mode_r, pll_usable_r;
    logic        codec_root_clock_r, gpio_clock_out_r;
    logic [2:0]  pll_ref_scale_r;
    logic [3:0]  pll_mult_scale_r;
    logic [5:0]  pll_whole_mult_r;
    logic [13:0] pll_frac_part_r, frac_m;
    logic [1:0]  root_src_sel_r;
    logic [7:0]  mdl [int];
    int          num_errors, samples_checked, cyc, n, seed;

    apcg_top #(.SETTLE_CYCLES(SETTLE)) uut (.clock, .resetn, .ce,
        .reg_page, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
        .mclk_pin, .bclk_pin, .gpio_pin, .pll_clock_in, .pll_gpio_route,
        .pll_enable_r, .pll_range_mode_r, .pll_ref_scale_r,
        .pll_mult_scale_r, .pll_whole_mult_r, .pll_frac_part_r,
        .root_src_sel_r, .pll_usable_r, .codec_root_clock_r,
        .gpio_clock_out_r);
    apcg_clk_src u_src (.mclk_pin, .bclk_pin, .gpio_pin, .pll_clock_in);

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    // ==========================================================
    // Model, bus and compare tasks
    task automatic finish_test;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic mdl_reset;
        mdl[4] = APCG_RST_ROOT_SEL;
        mdl[5] = APCG_RST_PLL_CTRL;
        mdl[6] = APCG_RST_PLL_WHOLE;
        mdl[7] = APCG_RST_FRAC_UPPER;
        mdl[8] = APCG_RST_FRAC_LOWER;
        frac_m = 14'h0000;
    endtask
    task automatic wr(input logic [7:0] pg, input logic [6:0] a,
                      input logic [7:0] d);
        @(posedge clock) #1;
        {reg_page, reg_addr, reg_wdata, reg_wr} = {pg, a, d, 1'b1};
        @(posedge clock) #1;
        reg_wr = 1'b0;
        if (pg == 8'h00 && a == 7'h08)
            frac_m = {mdl[7][5:0], d};
        if (pg == 8'h00 && mdl.exists(a))
            mdl[a] = d;
    endtask
    task automatic chk_rd(input logic [7:0] pg, input logic [6:0] a);
        logic [7:0] e;
        e = (pg == 8'h00 && mdl.exists(a)) ? mdl[a] : 8'h00;
        @(posedge clock) #1;
        {reg_page, reg_addr, reg_rd} = {pg, a, 1'b1};
        @(posedge clock) #1;
        reg_rd = 1'b0;
        cmp("rdata", 16'(e), 16'(reg_rdata_r));
    endtask
    task automatic chk_fields;
        repeat (3) @(posedge clock);
        #1;
        cmp("ctrl", 16'(mdl[5]), 16'({pll_enable_r, pll_ref_scale_r,
            pll_mult_scale_r}));
        cmp("whole", 16'(mdl[6][5:0]), 16'(pll_whole_mult_r));
        cmp("root", 16'({mdl[4][6], mdl[4][1:0]}),
            16'({pll_range_mode_r, root_src_sel_r}));
        cmp("frac", 16'(frac_m), 16'(pll_frac_part_r));
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        seed = 32'h785C;
        {resetn, ce, reg_wr, reg_rd, pll_gpio_route} = 5'b01000;
        {reg_page, reg_addr, reg_wdata} = 23'h000000;
        mdl_reset();
        repeat (6) @(posedge clock);
        #1 resetn = 1'b1;
        for (n = 4; n <= 8; n++)
            chk_rd(8'h00, 7'(n));
        chk_fields();
        // Random settings kept in the documented ranges
        repeat (4)
        begin
            v = 8'($random(seed));
            wr(8'h00, 7'h05, {1'b0, v[6:4], 4'(1 + v[1:0])});
            wr(8'h00, 7'h06, 8'(1 + (v % 63)));
            wr(8'h00, 7'h07, 8'(v % 39));
            chk_fields();
            wr(8'h00, 7'h08, 8'($random(seed)));
            chk_fields();
            for (n = 4; n <= 8; n++)
                chk_rd(8'h00, 7'(n));
        end
        wr(8'h01, 7'h05, 8'hFF);
        wr(8'h00, 7'h09, 8'hA5);
        chk_rd(8'h01, 7'h05);
        chk_rd(8'h00, 7'h09);
        chk_fields();
        // Pin sources first; the PLL source only once it is powered
        for (n = 0; n < 3; n++)
        begin
            wr(8'h00, 7'h04, 8'(n) | 8'h40);
            chk_fields();
            repeat (8) @(posedge clock);
        end
        // Output between 98 and 111 MHz in range mode 1
        wr(8'h00, 7'h06, 8'h08);
        pll_gpio_route = 1'b1;
        // PLL up before its dependants, then root moved onto it
        wr(8'h00, 7'h05, 8'h91);
        n = cyc;
        wr(8'h00, 7'h04, 8'h43);
        chk_fields();
        cmp("gated", 16'h0000, 16'(codec_root_clock_r));
        while (pll_usable_r !== 1'b1 && cyc < n + 100)
            @(posedge clock) #1;
        cmp("settle", 16'(SETTLE + 3), 16'(cyc - n));
        v = 8'h00;
        repeat (200)
        begin
            @(posedge clock) #1;
            v |= {4'h0, gpio_clock_out_r, !gpio_clock_out_r,
                  codec_root_clock_r, !codec_root_clock_r};
        end
        cmp("pll out", 16'h000F, 16'(v));
        // Root back to the pin first, PLL down last
        wr(8'h00, 7'h04, 8'h00);
        wr(8'h00, 7'h05, 8'h11);
        chk_fields();
        cmp("usable", 16'h0000, 16'(pll_usable_r));
        wr(8'h00, 7'h06, 8'h3F);
        resetn = 1'b0;
        mdl_reset();
        @(posedge clock) #1;
        resetn = 1'b1;
        // A write with the clock enable low must leave all state alone
        ce = 1'b0;
        wr(8'h00, 7'h06, 8'h15);
        ce = 1'b1;
        mdl[6] = APCG_RST_PLL_WHOLE;
        chk_rd(8'h00, 7'h06);
        chk_fields();
        finish_test();
    end
endmodule
